// ==== logic/timer_output_disable_control.sv ====
/*
 * Port output-disable logic for motor-control and PWM timer pins.
 * Assumes all inputs are synchronous to clk_i, that software holds the
 * disable request until it wishes timer control restored, and that the
 * testbench resolves each pin wire from pin_out_o and pin_oe_o.
 * Limitation: a pin switched to general I/O drives whatever the port
 * settings hold at that moment, so software should set direction and
 * data before the pin can be tripped.
 */
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// How it works
// [RL1] On a request, pins selected in any hi-Z select word go hi-Z.
// [RL2] On a request, pins selected in a port-switch word go to general I/O.
// [RL3] A pin in both kinds of word goes hi-Z and its port switch is ignored.
// [RL4] A switched pin takes its level and direction from the port settings.
// [RL5] A hi-Z pin reads as undefined, shown by its read-valid bit being low.
// [RL6] A pin taken over by port switching reads back its real level.
// [RL7] Software never lets both disable units act on one PWM pin at once.
// [RL8] Each timer pin can carry the timer signal normal or inverted.
// [RL9] Inverted motor-timer output flips the control and pin active levels.
// [RL10] Software sets motor conduction levels to the levels on the pins.
// [RL11] Inverted PWM output flips the pin level; software matches its levels.
// [RL12] Software clears a pin's hi-Z select bit before using its switch.
// [RL13] Pins stay disabled until the request drops; then the timer returns.
module timer_output_disable_control (
    input  wire logic                             clk_i,          // Clock.
    input  wire logic                             arst_n_i,       // Reset.
    input  wire logic                             disable_req_i,  // Request.
    input  wire output_disable_pkg::disable_sel_t sel_i,          // Selects.
    input  wire output_disable_pkg::port_cfg_t    port_cfg_i,     // GPIO.
    input  wire output_disable_pkg::timer_cfg_t   timer_cfg_i,    // Timer.
    input  wire logic [15:0]                      level_ctrl_i,   // Levels.
    input  wire logic [15:0]                      pin_in_i,       // Pin in.
    output logic [15:0]                           pin_out_o,      // Pin out.
    output logic [15:0]                           pin_oe_o,       // Pin OE.
    output logic [15:0]                           pin_read_o,     // Readback.
    output logic [15:0]                           read_valid_o,   // Read ok.
    output logic [15:0]                           active_lvl_o,   // Eff lvl.
    output logic [15:0]                           hiz_mask_o,     // Hi-Z.
    output logic [15:0]                           gpio_mask_o,    // GPIO.
    output logic                                  disabled_o      // Active.
);

    ////////////////////////////////////////////////////////////////////////
    // Select decoding.

    // Any of the four words claims the pin.
    function automatic logic [15:0] any_sel(input logic [3:0][15:0] w);
        logic [15:0] acc;
        acc = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            acc = acc | w[k];
        end
        any_sel = acc;
    endfunction : any_sel

    logic [15:0] hiz_any;
    logic [15:0] sw_any;

    always_comb begin
        hiz_any = any_sel(sel_i.hiz_sel) &
                  {16{output_disable_pkg::SEL_ON}};             // RL1
        sw_any  = any_sel(sel_i.switch_sel) & ~hiz_any;         // RL2 RL3
    end

    ////////////////////////////////////////////////////////////////////////
    // Ownership state. The masks are latched on the request edge and together only
    // gain pins while the request stays high (a switched pin may move to hi-Z), so a select change mid-fault cannot
    // briefly hand a tripped pin back to the timer. The trade-off is that
    // pins only return to the timer together, once the whole request
    // drops, never one at a time.

    logic [15:0] hiz_mask_reg;
    logic [15:0] hiz_mask_next;
    logic [15:0] gpio_mask_reg;
    logic [15:0] gpio_mask_next;
    logic        disabled_reg;
    logic        disabled_next;

    always_comb begin
        hiz_mask_next  = hiz_mask_reg;
        gpio_mask_next = gpio_mask_reg;
        disabled_next  = disabled_reg;
        if (!disable_req_i) begin
            hiz_mask_next  = output_disable_pkg::RST_MASK;      // RL13
            gpio_mask_next = output_disable_pkg::RST_MASK;      // RL13
            disabled_next  = 1'b0;
        end else if (!disabled_reg) begin
            hiz_mask_next  = hiz_any;                           // RL1 RL3
            gpio_mask_next = sw_any;                            // RL2 RL3
            disabled_next  = 1'b1;
        end else begin
            // Late selections still join; hi-Z keeps priority.
            hiz_mask_next  = hiz_mask_reg | hiz_any;            // RL3
            gpio_mask_next = (gpio_mask_reg | sw_any) & ~hiz_mask_next;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hiz_mask_reg  <= output_disable_pkg::RST_MASK;
            gpio_mask_reg <= output_disable_pkg::RST_MASK;
            disabled_reg  <= output_disable_pkg::RST_DISABLED;
        end else begin
            hiz_mask_reg  <= hiz_mask_next;
            gpio_mask_reg <= gpio_mask_next;
            disabled_reg  <= disabled_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin owner. It is taken from the next masks, so a pin's drive
    // changes on the same edge as its ownership and a tripped pin never
    // spends a cycle under timer control.

    // Hi-Z outranks the port switch for a pin claimed by both kinds.
    function automatic output_disable_pkg::pin_owner_t owner_of(
        input logic hiz,
        input logic gpio
    );
        if (hiz) begin
            owner_of = output_disable_pkg::OWN_HIZ;             // RL3
        end else if (gpio) begin
            owner_of = output_disable_pkg::OWN_GPIO;
        end else begin
            owner_of = output_disable_pkg::OWN_TIMER;
        end
    endfunction : owner_of

    output_disable_pkg::pin_owner_t owner [output_disable_pkg::PIN_COUNT];

    always_comb begin
        for (int i = 0; i < output_disable_pkg::PIN_COUNT; i++) begin
            owner[i] = owner_of(hiz_mask_next[i], gpio_mask_next[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive and polarity.

    logic [15:0] pin_out_reg;
    logic [15:0] pin_out_next;
    logic [15:0] pin_oe_reg;
    logic [15:0] pin_oe_next;
    logic [15:0] lvl_reg;
    logic [15:0] lvl_next;

    always_comb begin
        // Polarity is applied after the timer, so the pin sees the
        // inverted active level for both timer kinds.
        pin_out_next = timer_cfg_i.timer_out ^ timer_cfg_i.invert; // RL8
        pin_oe_next  = timer_cfg_i.timer_oe;
        // Motor timer pins also invert the control active level; PWM pins
        // keep theirs and only the pin level flips.
        lvl_next = level_ctrl_i ^
                   (timer_cfg_i.invert & timer_cfg_i.is_motor);   // RL9 RL11
        // The overrides come after polarity, so a pin handed to general
        // I/O drives the port data as written, never inverted.
        for (int i = 0; i < output_disable_pkg::PIN_COUNT; i++) begin
            case (owner[i])
                output_disable_pkg::OWN_HIZ: begin
                    pin_out_next[i] = 1'b0;                     // RL1
                    pin_oe_next[i]  = 1'b0;                     // RL1
                end
                output_disable_pkg::OWN_GPIO: begin
                    pin_out_next[i] = port_cfg_i.data[i];       // RL4
                    pin_oe_next[i]  = port_cfg_i.dir[i];        // RL4
                end
                default: begin
                    // Timer drive, as set up above.
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_reg <= output_disable_pkg::RST_PIN_OUT;
            pin_oe_reg  <= output_disable_pkg::RST_PIN_OE;
            lvl_reg     <= output_disable_pkg::RST_LEVEL;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
            lvl_reg     <= lvl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback. A floating pin has no defined level, so it reads as zero
    // with its valid bit low rather than passing an arbitrary input on.
    // The current masks already match the pins that are being sampled.

    logic [15:0] read_reg;
    logic [15:0] read_next;
    logic [15:0] valid_reg;
    logic [15:0] valid_next;

    always_comb begin
        read_next  = pin_in_i & ~hiz_mask_reg;                  // RL5 RL6
        valid_next = ~hiz_mask_reg;                             // RL5 RL6
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_reg  <= output_disable_pkg::RST_LEVEL;
            valid_reg <= output_disable_pkg::RST_LEVEL;
        end else begin
            read_reg  <= read_next;
            valid_reg <= valid_next;
        end
    end

    assign pin_out_o    = pin_out_reg;
    assign pin_oe_o     = pin_oe_reg;
    assign pin_read_o   = read_reg;
    assign read_valid_o = valid_reg;
    assign active_lvl_o = lvl_reg;
    assign hiz_mask_o   = hiz_mask_reg;
    assign gpio_mask_o  = gpio_mask_reg;
    assign disabled_o   = disabled_reg;

endmodule : timer_output_disable_control

// ==== shared/output_disable_pkg.sv ====
/*
 * Shared constants and carrier types for the timer output-disable control.
 * Assumes one peripheral clock domain and that every select, port and
 * level setting arrives as a plain port from software-owned registers.
 */
package output_disable_pkg;

    localparam int PIN_COUNT = 16;

    // Select bit pattern that claims a pin for a disable action.
    localparam logic SEL_ON = 1'b1;

    // Reset values of the registered outputs.
    localparam logic [15:0] RST_PIN_OUT  = 16'h0000;
    localparam logic [15:0] RST_PIN_OE   = 16'h0000;
    localparam logic [15:0] RST_MASK     = 16'h0000;
    localparam logic [15:0] RST_LEVEL    = 16'h0000;
    localparam logic        RST_DISABLED = 1'b0;

    // Who currently owns a pin.
    typedef enum logic [1:0] {
        OWN_TIMER = 2'b00,
        OWN_GPIO  = 2'b01,
        OWN_HIZ   = 2'b10
    } pin_owner_t;

    // Disable selection: four high-impedance select words and four
    // port-switch select words, one bit per pin.
    typedef struct packed {
        logic [3:0][15:0] hiz_sel;
        logic [3:0][15:0] switch_sel;
    } disable_sel_t;

    // General I/O settings used once a pin is switched to port control.
    typedef struct packed {
        logic [15:0] dir;
        logic [15:0] data;
    } port_cfg_t;

    // Timer drive and polarity settings.
    typedef struct packed {
        logic [15:0] timer_out;
        logic [15:0] timer_oe;
        logic [15:0] invert;
        logic [15:0] is_motor;
    } timer_cfg_t;

endpackage : output_disable_pkg

// ==== tb/od_checker_assertions.sv ====
/* Checker for the output-disable block, bound to its top ports.
   Assumes one clock domain and the one-cycle latency of the block. */
`timescale 1ns/100ps
module od_checker (
    input wire logic                             clk_i,
    input wire logic                             arst_n_i,
    input wire logic                             disable_req_i,
    input wire output_disable_pkg::disable_sel_t sel_i,
    input wire output_disable_pkg::port_cfg_t    port_cfg_i,
    input wire output_disable_pkg::timer_cfg_t   timer_cfg_i,
    input wire logic [15:0]                      level_ctrl_i,
    input wire logic [15:0]                      pin_in_i,
    input wire logic [15:0]                      pin_out_o,
    input wire logic [15:0]                      pin_oe_o,
    input wire logic [15:0]                      pin_read_o,
    input wire logic [15:0]                      read_valid_o,
    input wire logic [15:0]                      active_lvl_o,
    input wire logic [15:0]                      hiz_mask_o,
    input wire logic [15:0]                      gpio_mask_o,
    input wire logic                             disabled_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic        run_reg;
    logic [15:0] hz, sw, tinv, lvl;
    // Outputs lag by one edge, so the first edge after reset is skipped.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) run_reg <= 1'b0;
        else run_reg <= 1'b1;
    end
    always_comb begin
        hz = sel_i.hiz_sel[0] | sel_i.hiz_sel[1] | sel_i.hiz_sel[2]
            | sel_i.hiz_sel[3];
        sw = sel_i.switch_sel[0] | sel_i.switch_sel[1]
            | sel_i.switch_sel[2] | sel_i.switch_sel[3];
        tinv = timer_cfg_i.timer_out ^ timer_cfg_i.invert;
        lvl = level_ctrl_i ^ (timer_cfg_i.invert & timer_cfg_i.is_motor);
    end
    a_hiz_capture: assert property (disable_req_i |=> disabled_o
        && (hiz_mask_o & $past(hz)) == $past(hz)) else $error("Hi-Z miss");
    a_hiz_undriven: assert property (
        (pin_oe_o & hiz_mask_o) == 16'h0000) else $error("Hi-Z pin driven");
    a_gpio_capture: assert property (disable_req_i |=>
        ((hiz_mask_o | gpio_mask_o) & $past(sw)) == $past(sw))
        else $error("Switch miss");
    a_hiz_priority: assert property (
        (gpio_mask_o & hiz_mask_o) == 16'h0000) else $error("Both masks set");
    a_gpio_drive: assert property (run_reg |-> (((pin_out_o
        ^ $past(port_cfg_i.data)) | (pin_oe_o ^ $past(port_cfg_i.dir)))
        & gpio_mask_o) == 16'h0000) else $error("Port drive wrong");
    a_read_undef: assert property (run_reg |->
        read_valid_o == ~$past(hiz_mask_o)) else $error("Valid wrong");
    a_read_normal: assert property (run_reg |-> ((pin_read_o
        ^ $past(pin_in_i)) & read_valid_o) == 16'h0000)
        else $error("Readback wrong");
    a_timer_path: assert property (run_reg |->
        ((pin_out_o ^ $past(tinv)) & ~(hiz_mask_o | gpio_mask_o))
        == 16'h0000) else $error("Timer out");
    a_level_invert: assert property (run_reg |->
        active_lvl_o == $past(lvl)) else $error("Active level wrong");
    a_release_all: assert property (!disable_req_i |=> !disabled_o
        && (hiz_mask_o | gpio_mask_o) == 16'h0000) else $error("No release");
    c_disable: cover property (disable_req_i ##1 disabled_o);
    c_switch: cover property (disabled_o && gpio_mask_o != 16'h0000);
    c_release: cover property ($fell(disabled_o));
endmodule : od_checker
bind timer_output_disable_control od_checker chk (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .disable_req_i (disable_req_i),
    .sel_i         (sel_i),
    .port_cfg_i    (port_cfg_i),
    .timer_cfg_i   (timer_cfg_i),
    .level_ctrl_i  (level_ctrl_i),
    .pin_in_i      (pin_in_i),
    .pin_out_o     (pin_out_o),
    .pin_oe_o      (pin_oe_o),
    .pin_read_o    (pin_read_o),
    .read_valid_o  (read_valid_o),
    .active_lvl_o  (active_lvl_o),
    .hiz_mask_o    (hiz_mask_o),
    .gpio_mask_o   (gpio_mask_o),
    .disabled_o    (disabled_o)
);

// ==== tb/power_stage_model.sv ====
/* Power-stage side of the timer pins: resolves each pin wire.
   Assumes no pull resistors on the lines. */
`timescale 1ns/100ps
module power_stage_model (
    input  wire logic        clk_i,  // Clock.
    input  wire logic [15:0] drv_i,  // Driven level.
    input  wire logic [15:0] oe_i,   // Drive enable.
    output logic      [15:0] pin_o   // Wire level.
);
    logic [15:0] last_reg = 16'h0000;
    // A released pin flips every cycle so a stale level never reads valid.
    assign pin_o = (oe_i & drv_i) | (~oe_i & ~last_reg);
    // Plain always, since the start value comes from the declaration.
    always @(posedge clk_i) last_reg <= pin_o;
endmodule : power_stage_model

// ==== tb/tb.sv ====
/* Self-checking bench for the output-disable block.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic disable_req_i = 1'b0;
    output_disable_pkg::disable_sel_t sel_i = '0;
    output_disable_pkg::port_cfg_t    port_cfg_i = '0;
    output_disable_pkg::timer_cfg_t   timer_cfg_i = '0;
    logic [15:0] level_ctrl_i = 16'h0000;
    logic [15:0] pin_in_i, pin_out_o, pin_oe_o, pin_read_o, read_valid_o;
    logic [15:0] active_lvl_o, hiz_mask_o, gpio_mask_o;
    logic        disabled_o;
    int          failures = 0;
    int          tests_run = 0;
    timer_output_disable_control dut (
        .clk_i         (clk_i),
        .arst_n_i      (arst_n_i),
        .disable_req_i (disable_req_i),
        .sel_i         (sel_i),
        .port_cfg_i    (port_cfg_i),
        .timer_cfg_i   (timer_cfg_i),
        .level_ctrl_i  (level_ctrl_i),
        .pin_in_i      (pin_in_i),
        .pin_out_o     (pin_out_o),
        .pin_oe_o      (pin_oe_o),
        .pin_read_o    (pin_read_o),
        .read_valid_o  (read_valid_o),
        .active_lvl_o  (active_lvl_o),
        .hiz_mask_o    (hiz_mask_o),
        .gpio_mask_o   (gpio_mask_o),
        .disabled_o    (disabled_o)
    );
    power_stage_model stage (.clk_i(clk_i), .drv_i(pin_out_o),
        .oe_i(pin_oe_o), .pin_o(pin_in_i));
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        step(12);
        check(pin_oe_o | hiz_mask_o | read_valid_o, 16'h0000);
        arst_n_i = 1'b1;
        timer_cfg_i = {16'h00f0, 16'hffff, 16'h0ff0, 16'h00ff};
        level_ctrl_i = 16'h1234;
        step(2);
        check(pin_out_o, 16'h0f00);
        check(active_lvl_o, 16'h12c4);
        $display("Test timer polarity done");
        // Pin 0 sits in both selects on purpose to see hi-Z win.
        sel_i.hiz_sel = {16'h1000, 16'h0100, 16'h0010, 16'h0001};
        sel_i.switch_sel = {16'h0080, 16'h0000, 16'h0000, 16'h0003};
        port_cfg_i = {16'h0002, 16'h0002};
        disable_req_i = 1'b1;
        step(1);
        check({15'h0000, disabled_o}, 16'h0001);
        check(hiz_mask_o, 16'h1111);
        check(gpio_mask_o, 16'h0082);
        check(pin_oe_o, 16'hee6e);
        check(pin_out_o & 16'h0082, 16'h0002);
        step(2);
        check(read_valid_o, 16'heeee);
        check(pin_read_o & 16'h1113, 16'h0002);
        $display("Test disable done");
        sel_i.hiz_sel[1] = 16'h0030;
        sel_i.switch_sel[3] = 16'h0000;
        step(1);
        check(hiz_mask_o, 16'h1131);
        check(gpio_mask_o, 16'h0082);
        disable_req_i = 1'b0;
        step(1);
        check(hiz_mask_o | gpio_mask_o, 16'h0000);
        check(pin_out_o, 16'h0f00);
        check(pin_oe_o, 16'hffff);
        step(1);
        check(read_valid_o, 16'hffff);
        $display("Test release done");
        // Pins 0 and 1 are switched with their hi-Z bits clear; pin 8 is claimed for hi-Z.
        sel_i.hiz_sel = {16'h0000, 16'h0000, 16'h0000, 16'h0100};
        sel_i.switch_sel = {16'h0000, 16'h0000, 16'h0000, 16'h0003};
        port_cfg_i = {16'h0003, 16'h0001};
        disable_req_i = 1'b1;
        step(1);
        check(gpio_mask_o, 16'h0003);
        check(pin_out_o & 16'h0003, 16'h0001);
        check(pin_oe_o & 16'h0103, 16'h0003);
        step(1);
        check(pin_read_o & 16'h0003, 16'h0001);
        arst_n_i = 1'b0;
        #1;
        check(gpio_mask_o | hiz_mask_o | pin_oe_o, 16'h0000);
        check({15'h0000, disabled_o}, 16'h0000);
        step(2);
        arst_n_i = 1'b1;
        step(1);
        check(gpio_mask_o, 16'h0003);
        check(hiz_mask_o, 16'h0100);
        disable_req_i = 1'b0;
        step(2);
        check(hiz_mask_o | gpio_mask_o, 16'h0000);
        check(read_valid_o, 16'hffff);
        $display("Test reset in mid-run done");
        results();
    end
endmodule : tb
